// File: src/cpa_regs.sv
// wishbone register slice: codec power control, audio control three, first bass coefficient
`default_nettype none
`include "cpa_consts.svh"

// Behaviour
// - bit 15 powers down handset mic bias
// - bit 14 powers down headset mic bias
// - bit 13 powers down analog sidetone
// - bits 12, 11 power down speaker outputs
// - bits 10, 9 power down converters
// - bits 8, 7 power down ground, common
// - bit 6 powers down loudspeaker driver
// - all ten bits set: codec fully down
// - record and sidetone done flags, read-only
// - left and right playback done flags
// - bit 1 enables effects filter
// - bit 0 enables de-emphasis filter
// - volume link field couples channel volumes
// - reference rate bit selects 48 or 44.1
// - transfer mode: continuous or 256-s
// - role bit selects slave or master
// - record overflow sets, clears on read
// - playback overflows set, clear on read
// - clip stepping only while agc selected
// - revision field read-only, writes ignored
// - coefficient register resets to 27619
module cpa_regs
#(
	parameter logic [2:0] REVISION = `CPA_REV_DEFAULT  // arbitrary value
)
(
	input  wire logic                  clk_i,                  // codec clock, 20 MHz
	input  wire logic                  rst_i,                  // synchronous, active high
	input  wire logic                  wb_cyc_i,               // bus cycle
	input  wire logic                  wb_stb_i,               // strobe
	input  wire logic                  wb_we_i,                // write enable
	input  wire logic [`CPA_ADR_W-1:0] wb_adr_i,               // byte address
	input  wire logic [`CPA_SEL_W-1:0] wb_sel_i,               // byte enables
	input  wire logic [`CPA_DAT_W-1:0] wb_dat_i,               // write data
	output logic      [`CPA_DAT_W-1:0] wb_dat_o,               // read data
	output logic                       wb_ack_o,               // acknowledge
	input  wire logic                  record_pd_done_i,       // async pin
	input  wire logic                  left_play_pd_done_i,    // async pin
	input  wire logic                  right_play_pd_done_i,   // async pin
	input  wire logic                  sidetone_pd_done_i,     // async pin
	input  wire logic                  record_overflow_i,      // one-cycle event
	input  wire logic                  left_play_overflow_i,   // one-cycle event
	input  wire logic                  right_play_overflow_i,  // one-cycle event
	input  wire logic                  agc_selected_i,         // agc on mic input
	output logic                       handset_bias_pd_o,      // 1 = down
	output logic                       headset_bias_pd_o,      // 1 = down
	output logic                       sidetone_pd_o,          // 1 = down
	output logic                       speaker_one_pd_o,       // 1 = down
	output logic                       speaker_two_pd_o,       // 1 = down
	output logic                       playback_conv_pd_o,     // 1 = down
	output logic                       record_conv_pd_o,       // 1 = down
	output logic                       virtual_ground_pd_o,    // 1 = down
	output logic                       common_out_pd_o,        // 1 = down
	output logic                       loudspeaker_pd_o,       // 1 = down
	output logic                       codec_all_pd_o,         // whole section down
	output logic                       effects_filter_en_o,    // effects filter on
	output logic                       deemphasis_en_o,        // de-emphasis on
	output logic                       left_vol_from_right_o,  // left uses right volume
	output logic                       right_vol_from_left_o,  // right uses left volume
	output logic                       reference_rate_sel_o,   // 0 = 48.0, 1 = 44.1
	output logic                       transfer_mode_sel_o,    // 1 = 256-s mode
	output logic                       role_select_o,          // 1 = master
	output logic                       agc_clip_step_ctrl_o,   // effective clip stepping
	output logic      [`CPA_REG_W-1:0] left_bass_coeff_zero_o  // signed coefficient
);

	// ---------------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------------
	// map a register index to a target; used by write and read paths
	function automatic cpa_pkg::cpa_reg_sel_t reg_decode(input cpa_pkg::cpa_index_t idx);
		case (idx)
			`CPA_IDX_PWR:  reg_decode = cpa_pkg::CPA_SEL_PWR;
			`CPA_IDX_AUD:  reg_decode = cpa_pkg::CPA_SEL_AUD;
			`CPA_IDX_COEF: reg_decode = cpa_pkg::CPA_SEL_COEF;
			default:       reg_decode = cpa_pkg::CPA_SEL_NONE;
		endcase
	endfunction

	// byte-lane merge limited to the writable bits of a register
	function automatic cpa_pkg::cpa_word_t lane_merge(
		input cpa_pkg::cpa_word_t old_v,
		input cpa_pkg::cpa_word_t new_v,
		input logic [1:0]         sel,
		input cpa_pkg::cpa_word_t wmask
	);
		cpa_pkg::cpa_word_t lanes;
		lanes = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
		lane_merge = (old_v & ~lanes) | (new_v & lanes);
	endfunction

	// ---------------------------------------------------------------------
	// bus request
	// ---------------------------------------------------------------------
	logic                  ack_q;     // registered acknowledge
	logic [`CPA_DAT_W-1:0] rdata_q;   // registered read data
	logic                  req;       // new request this cycle
	logic                  wr_req;    // write taken
	logic                  rd_req;    // read taken
	cpa_pkg::cpa_index_t   idx;       // register index
	cpa_pkg::cpa_reg_sel_t tgt;       // decoded target
	cpa_pkg::cpa_word_t    wdata;     // low half of write data

	// a request is taken once; the ack beat blocks a second take
	assign req    = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_req = req && wb_we_i;
	assign rd_req = req && !wb_we_i;
	assign idx    = wb_adr_i[`CPA_IDX_HI:`CPA_IDX_LO];
	assign tgt    = reg_decode(idx);
	assign wdata  = wb_dat_i[`CPA_REG_W-1:0];

	// ack one cycle after the take, for mapped and unmapped alike
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'h0;
		else
			ack_q <= req;
	end

	// ---------------------------------------------------------------------
	// power control register
	// ---------------------------------------------------------------------
	cpa_pkg::cpa_word_t pwr_q;    // writable power bits, flag lanes held zero
	logic               all_pd_q; // whole-section power down

	// power-down and filter enable storage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pwr_q <= `CPA_PWR_RST;
		else if (wr_req && tgt == cpa_pkg::CPA_SEL_PWR)
			pwr_q <= lane_merge(pwr_q, wdata, wb_sel_i[1:0], `CPA_PWR_WMASK);
	end

	// full power-down when every section bit is set; one cycle behind the bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			all_pd_q <= 1'h1;
		else
			all_pd_q <= &pwr_q[`CPA_PWR_HND:`CPA_PWR_LSPK];
	end

	// section power-down outputs straight from storage
	assign handset_bias_pd_o   = pwr_q[`CPA_PWR_HND];
	assign headset_bias_pd_o   = pwr_q[`CPA_PWR_HED];
	assign sidetone_pd_o       = pwr_q[`CPA_PWR_STP];
	assign speaker_one_pd_o    = pwr_q[`CPA_PWR_SP1];
	assign speaker_two_pd_o    = pwr_q[`CPA_PWR_SP2];
	assign playback_conv_pd_o  = pwr_q[`CPA_PWR_DAC];
	assign record_conv_pd_o    = pwr_q[`CPA_PWR_ADC];
	assign virtual_ground_pd_o = pwr_q[`CPA_PWR_DRIVER_VIRTUAL_GROUND];
	assign common_out_pd_o     = pwr_q[`CPA_PWR_COUT];
	assign loudspeaker_pd_o    = pwr_q[`CPA_PWR_LSPK];
	assign effects_filter_en_o = pwr_q[`CPA_PWR_EFF];
	assign deemphasis_en_o     = pwr_q[`CPA_PWR_DEE];
	assign codec_all_pd_o      = all_pd_q;

	// ---------------------------------------------------------------------
	// power-down-done status
	// ---------------------------------------------------------------------
	logic [`CPA_DONE_W-1:0] done_w;  // {record, left, right, sidetone}

	// analog pins arrive unclocked; filter them before software sees them
	cpa_sync3 u_done_sync
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({record_pd_done_i, left_play_pd_done_i,
		           right_play_pd_done_i, sidetone_pd_done_i}),
		.level_o (done_w)
	);

	// ---------------------------------------------------------------------
	// audio control three register
	// ---------------------------------------------------------------------
	cpa_pkg::cpa_word_t aud_q;     // writable control bits incl. reserved storage
	logic               rec_ovf_q; // record overflow
	logic               lft_ovf_q; // left playback overflow
	logic               rgt_ovf_q; // right playback overflow
	logic               rd_aud;    // read of this register taken
	logic               l_from_r_q;// decoded volume link
	logic               r_from_l_q;// decoded volume link
	logic               clip_q;    // gated clip stepping

	assign rd_aud = rd_req && tgt == cpa_pkg::CPA_SEL_AUD;

	// control storage; flag and revision lanes are masked off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			aud_q <= `CPA_AUD_RST;
		else if (wr_req && tgt == cpa_pkg::CPA_SEL_AUD)
			aud_q <= lane_merge(aud_q, wdata, wb_sel_i[1:0], `CPA_AUD_WMASK);
	end

	// overflow flags; an event in the clearing read's cycle wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rec_ovf_q <= 1'h0;
			lft_ovf_q <= 1'h0;
			rgt_ovf_q <= 1'h0;
		end
		else
		begin
			rec_ovf_q <= record_overflow_i || (rec_ovf_q && !rd_aud);
			lft_ovf_q <= left_play_overflow_i || (lft_ovf_q && !rd_aud);
			rgt_ovf_q <= right_play_overflow_i || (rgt_ovf_q && !rd_aud);
		end
	end

	// volume link decode; 00 and 11 both leave channels independent
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			l_from_r_q <= 1'h0;
			r_from_l_q <= 1'h0;
		end
		else
		begin
			l_from_r_q <= aud_q[`CPA_AUD_VOL_HI:`CPA_AUD_VOL_LO] == `CPA_VOL_L_FROM_R;
			r_from_l_q <= aud_q[`CPA_AUD_VOL_HI:`CPA_AUD_VOL_LO] == `CPA_VOL_R_FROM_L;
		end
	end

	// clip stepping has no effect unless agc drives the mic input
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			clip_q <= 1'h0;
		else
			clip_q <= aud_q[`CPA_AUD_CLIP] && agc_selected_i;
	end

	// rate select feeds de-emphasis, agc timing and measurement dividers alike
	assign reference_rate_sel_o  = aud_q[`CPA_AUD_REF];
	assign transfer_mode_sel_o   = aud_q[`CPA_AUD_XFM];
	assign role_select_o         = aud_q[`CPA_AUD_ROLE];
	assign left_vol_from_right_o = l_from_r_q;
	assign right_vol_from_left_o = r_from_l_q;
	assign agc_clip_step_ctrl_o  = clip_q;

	// ---------------------------------------------------------------------
	// coefficient register
	// ---------------------------------------------------------------------
	cpa_pkg::cpa_word_t coef_q;  // left bass coefficient zero, signed

	// full read/write word, both lanes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			coef_q <= `CPA_COEF_RST;
		else if (wr_req && tgt == cpa_pkg::CPA_SEL_COEF)
			coef_q <= lane_merge(coef_q, wdata, wb_sel_i[1:0], `CPA_COEF_WMASK);
	end

	assign left_bass_coeff_zero_o = coef_q;

	// ---------------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------------
	cpa_pkg::cpa_word_t rd_mux;  // selected register view

	// flags and revision are overlaid on storage; reserved bits 10:9 stay zero
	always_comb
	begin
		rd_mux = 16'h0000;
		case (tgt)
			cpa_pkg::CPA_SEL_PWR:
			begin
				rd_mux = pwr_q;
				rd_mux[`CPA_PWR_ADF] = done_w[3];
				rd_mux[`CPA_PWR_LDF] = done_w[2];
				rd_mux[`CPA_PWR_RDF] = done_w[1];
				rd_mux[`CPA_PWR_STF] = done_w[0];
			end
			cpa_pkg::CPA_SEL_AUD:
			begin
				rd_mux = aud_q;
				rd_mux[`CPA_AUD_ROVF]  = rec_ovf_q;
				rd_mux[`CPA_AUD_LOVF]  = lft_ovf_q;
				rd_mux[`CPA_AUD_RROVF] = rgt_ovf_q;
				rd_mux[`CPA_AUD_REV_HI:`CPA_AUD_REV_LO] = REVISION;
			end
			cpa_pkg::CPA_SEL_COEF:
				rd_mux = coef_q;
			default:
				rd_mux = 16'h0000;  // unmapped reads zero
		endcase
	end

	// data captured at the take edge, held through the ack beat
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_q <= 32'h0000_0000;
		else if (rd_req)
			rdata_q <= {16'h0000, rd_mux};
	end

	assign wb_dat_o = rdata_q;
	assign wb_ack_o = ack_q;

	// ---------------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ACK_AFTER_TAKE: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single beat after take");
	AST_HND_WRITE: assert property (
		(wr_req && tgt == cpa_pkg::CPA_SEL_PWR && wb_sel_i[1])
		|=> handset_bias_pd_o == $past(wb_dat_i[15]))
		else $error("handset bias bit not written");
	AST_ALL_PD: assert property (
		(&pwr_q[`CPA_PWR_HND:`CPA_PWR_LSPK]) [*2] |-> codec_all_pd_o)
		else $error("full power down missing");
	AST_NOT_ALL_PD: assert property (
		!loudspeaker_pd_o |=> !codec_all_pd_o)
		else $error("full power down with a section up");
	AST_DONE_READ: assert property (
		(rd_req && tgt == cpa_pkg::CPA_SEL_PWR) |=> wb_dat_o[5] == $past(done_w[3]))
		else $error("record done flag misread");
	AST_OVF_SET: assert property (
		record_overflow_i |=> rec_ovf_q ##1 (rec_ovf_q || $past(rd_aud)))
		else $error("record overflow not held");
	AST_OVF_CLR: assert property (
		(rd_aud && !left_play_overflow_i) |=> !lft_ovf_q)
		else $error("left overflow not cleared by read");
	AST_REV_RO: assert property (
		rd_aud |=> wb_dat_o[2:0] == REVISION && wb_dat_o[10:9] == 2'h0)
		else $error("revision or reserved bits wrong");
	AST_CLIP_GATE: assert property (
		!agc_selected_i |=> !agc_clip_step_ctrl_o)
		else $error("clip stepping active without agc");
	AST_VOL_LINK: assert property (
		aud_q[15:14] == `CPA_VOL_L_FROM_R |=> left_vol_from_right_o && !right_vol_from_left_o)
		else $error("volume link decode wrong");
	AST_COEF_RST: assert property (
		$past(rst_i) |-> left_bass_coeff_zero_o == `CPA_COEF_RST)
		else $error("coefficient reset value wrong");

	COV_PWR_WRITE: cover property (wr_req && tgt == cpa_pkg::CPA_SEL_PWR);
	COV_OVF_CLEAR: cover property (rec_ovf_q && rd_aud ##1 !rec_ovf_q);
	COV_ALL_UP:    cover property (codec_all_pd_o ##1 !codec_all_pd_o);

endmodule

`default_nettype wire

// File: pkg/cpa_consts.svh
// offsets, field positions, reset values and widths of the codec power/audio register slice
`ifndef CPA_CONSTS_SVH
`define CPA_CONSTS_SVH

// ---------------------------------------------------------------------
// bus geometry
// ---------------------------------------------------------------------
`define CPA_ADR_W        8
`define CPA_DAT_W        32
`define CPA_SEL_W        4
`define CPA_REG_W        16
`define CPA_IDX_LO       2
`define CPA_IDX_HI       7

// ---------------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------------
`define CPA_IDX_PWR      6'h05
`define CPA_IDX_AUD      6'h06
`define CPA_IDX_COEF     6'h07

// ---------------------------------------------------------------------
// power control fields
// ---------------------------------------------------------------------
`define CPA_PWR_HND      4'hF
`define CPA_PWR_HED      4'hE
`define CPA_PWR_STP      4'hD
`define CPA_PWR_SP1      4'hC
`define CPA_PWR_SP2      4'hB
`define CPA_PWR_DAC      4'hA
`define CPA_PWR_ADC      4'h9
`define CPA_PWR_DRIVER_VIRTUAL_GROUND     4'h8
`define CPA_PWR_COUT     4'h7
`define CPA_PWR_LSPK     4'h6
`define CPA_PWR_ADF      4'h5
`define CPA_PWR_LDF      4'h4
`define CPA_PWR_RDF      4'h3
`define CPA_PWR_STF      4'h2
`define CPA_PWR_EFF      4'h1
`define CPA_PWR_DEE      4'h0
`define CPA_PWR_RST      16'hFFC0
`define CPA_PWR_WMASK    16'hFFC3

// ---------------------------------------------------------------------
// audio control three fields
// ---------------------------------------------------------------------
`define CPA_AUD_VOL_HI   4'hF
`define CPA_AUD_VOL_LO   4'hE
`define CPA_AUD_REF      4'hD
`define CPA_AUD_XFM      4'hC
`define CPA_AUD_ROLE     4'hB
`define CPA_AUD_ROVF     4'h8
`define CPA_AUD_LOVF     4'h7
`define CPA_AUD_RROVF    4'h6
`define CPA_AUD_CLIP     4'h3
`define CPA_AUD_RST      16'h0000
`define CPA_AUD_WMASK    16'hF838
`define CPA_AUD_REV_HI   4'h2
`define CPA_AUD_REV_LO   4'h0
`define CPA_VOL_L_FROM_R 2'h1
`define CPA_VOL_R_FROM_L 2'h2

// ---------------------------------------------------------------------
// coefficient, flags, revision
// ---------------------------------------------------------------------
`define CPA_COEF_RST     16'h6BE3
`define CPA_COEF_WMASK   16'hFFFF
`define CPA_DONE_RST     1'h1
`define CPA_DONE_W       4
`define CPA_REV_DEFAULT  3'h1

`endif

// File: pkg/cpa_pkg.sv
// shared types of the codec power/audio register slice
`default_nettype none

package cpa_pkg;
	// one register word as seen by software
	typedef logic [15:0] cpa_word_t;
	// register index taken from the bus address
	typedef logic [5:0] cpa_index_t;
	// which register an access targets
	typedef enum logic [1:0] {
		CPA_SEL_NONE,
		CPA_SEL_PWR,
		CPA_SEL_AUD,
		CPA_SEL_COEF
	} cpa_reg_sel_t;
endpackage

`default_nettype wire

// File: src/cpa_sync3.sv
// three-stage synchroniser for the power-down-done status pins
`default_nettype none
`include "cpa_consts.svh"

module cpa_sync3
(
	input  wire logic                   clk_i,    // codec clock
	input  wire logic                   rst_i,    // synchronous, active high
	input  wire logic [`CPA_DONE_W-1:0] async_i,  // raw status pins
	output logic      [`CPA_DONE_W-1:0] level_o   // filtered level
);

	// ---------------------------------------------------------------------
	// per-bit chain
	// ---------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `CPA_DONE_W; g = g + 1)
		begin : g_bit
			logic s1_q;  // first stage, read only by s2
			logic s2_q;  // second stage
			logic s3_q;  // third stage
			logic lv_q;  // accepted level

			// chain resets to done so nothing looks powered mid-reset
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					s1_q <= `CPA_DONE_RST;
					s2_q <= `CPA_DONE_RST;
					s3_q <= `CPA_DONE_RST;
				end
				else
				begin
					s1_q <= async_i[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end

			// a change counts once stage two and three agree
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					lv_q <= `CPA_DONE_RST;
				else if (s2_q == s3_q)
					lv_q <= s2_q;
			end

			assign level_o[g] = lv_q;
		end
	endgenerate

endmodule

`default_nettype wire

// File: tb/cpa_regs_tb.sv
// self-checking bench for the codec power/audio register slice
`default_nettype none
`include "cpa_consts.svh"

module cpa_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// stimulus, expectations and counters
	// ---------------------------------------------------------------
	typedef struct packed {logic chk; logic [31:0] val;} cpa_exp_t;
	localparam logic [2:0] REV    = 3'h5;                 // arbitrary revision value
	localparam logic [7:0] A_PWR  = {`CPA_IDX_PWR, 2'h0};  // byte addresses
	localparam logic [7:0] A_AUD  = {`CPA_IDX_AUD, 2'h0};
	localparam logic [7:0] A_COEF = {`CPA_IDX_COEF, 2'h0};
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, agc_selected_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, done_pins;                     // done: record, left, right, sidetone
	logic [31:0] wb_dat_i, wb_dat_o, d, ea, pd_vec;
	logic [2:0]  ovf;                                     // record, left, right overflow
	logic        wb_ack_o, h0, h1, s0, s1, s2, s3, s4, s5, v0, v1, v2, v3, all_pd;
	logic        eff, dee, lvr, rvl, rate, xfm, role, clip;
	logic [15:0] coef;
	logic [31:0] rs = 32'h0000D37E;                       // xorshift state, fixed seed
	cpa_exp_t    exp_q[$];                                // notes of expected answers
	cpa_exp_t    ent;
	int          err_total = 0;
	int          compares  = 0;
	assign pd_vec = {22'h0, h0, h1, s0, s1, s2, s3, s4, s5, v0, v1};

	cpa_regs #(.REVISION(REV)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.record_pd_done_i(done_pins[3]), .left_play_pd_done_i(done_pins[2]),
		.right_play_pd_done_i(done_pins[1]), .sidetone_pd_done_i(done_pins[0]),
		.record_overflow_i(ovf[2]), .left_play_overflow_i(ovf[1]),
		.right_play_overflow_i(ovf[0]), .agc_selected_i(agc_selected_i),
		.handset_bias_pd_o(h0), .headset_bias_pd_o(h1), .sidetone_pd_o(s0),
		.speaker_one_pd_o(s1), .speaker_two_pd_o(s2), .playback_conv_pd_o(s3),
		.record_conv_pd_o(s4), .virtual_ground_pd_o(s5), .common_out_pd_o(v0),
		.loudspeaker_pd_o(v1), .codec_all_pd_o(all_pd), .effects_filter_en_o(eff),
		.deemphasis_en_o(dee), .left_vol_from_right_o(lvr), .right_vol_from_left_o(rvl),
		.reference_rate_sel_o(rate), .transfer_mode_sel_o(xfm), .role_select_o(role),
		.agc_clip_step_ctrl_o(clip), .left_bass_coeff_zero_o(coef));

	// free-running 20 MHz clock
	initial
	begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// one comparison, counted, reported at once
	function automatic void chk(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endfunction

	// classic single cycle: hold the request until ack is sampled, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] dv, input logic c, input logic [31:0] e);
		int n;
		n = 0;
		exp_q.push_back('{c, e});
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= dv;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'h1 && n < 50);
		if (n >= 50)
			chk("wb_ack_o", 32'h1, 32'h0);
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] dv);
		bus(1'h1, a, s, dv, 1'h0, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 4'hF, rnd(), 1'h1, e);
	endtask

	task automatic finish_test();
		$display("TB: compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// answer watcher: oldest note against each acknowledged read
	always @(posedge clk_i)
		if (wb_ack_o === 1'h1 && exp_q.size() > 0)
		begin
			ent = exp_q.pop_front();
			if (ent.chk)
				chk("wb_dat_o", ent.val, wb_dat_o);
		end

	// hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		#250000;
		err_total++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		rst_i = 1'h1;
		{wb_cyc_i, wb_stb_i, wb_we_i, agc_selected_i} = 4'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i, ovf} = '0;
		done_pins = 4'hF;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		// reset values
		chk("pd_vec", 32'h3FF, pd_vec);
		chk("all_pd", 32'h1, {31'h0, all_pd});
		rd(A_PWR, 32'h0000FFFC);
		rd(A_AUD, {29'h0, REV});
		rd(A_COEF, 32'h00006BE3);
		$display("test reset_values done");
		// power word: boundaries then random, read-only bits kept
		for (int i = 0; i < 6; i++)
		begin
			d = (i == 0) ? 32'h0000FFC0 : (i == 1) ? 32'h0 : rnd();
			wr(A_PWR, 4'h3, d);
			rd(A_PWR, {16'h0, d[15:0] & `CPA_PWR_WMASK | 16'h003C});
			chk("pd_vec", {22'h0, d[15:6]}, pd_vec);
			chk("pd_vec_low", {22'h0, d[15:6]}, pd_vec);
			chk("all_pd", {31'h0, &d[15:6]}, {31'h0, all_pd});
			chk("filters", {30'h0, d[1:0]}, {30'h0, eff, dee});
		end
		// byte lanes: only enabled lanes change
		wr(A_PWR, 4'h3, 32'h0000FFFF);
		wr(A_PWR, 4'h1, 32'h0);
		wr(A_PWR, 4'hC, 32'h0);
		rd(A_PWR, 32'h0000FF3C);
		// done pins reach the status bits after synchronisation
		for (int i = 0; i < 3; i++)
		begin
			d = rnd();
			done_pins <= d[3:0];
			repeat (6) @(posedge clk_i);
			rd(A_PWR, {16'h0, 8'hFF, 2'h0, done_pins, 2'h0});
		end
		done_pins <= 4'hF;
		$display("test power_control done");
		// audio control: every volume link code, outputs and clip gating
		for (int i = 0; i < 8; i++)
		begin
			d = rnd();
			if (i < 4)
				d[15:14] = i[1:0];
			agc_selected_i <= d[20];
			wr(A_AUD, 4'h3, d);
			ea = {16'h0, d[15:0] & `CPA_AUD_WMASK | {13'h0, REV}};
			rd(A_AUD, ea);
			chk("vol_link", {30'h0, d[15:14] == 2'h1, d[15:14] == 2'h2},
				{30'h0, lvr, rvl});
			// rate bit is free here: no reference above 48 kHz is modelled
			chk("rate_mode_role", {29'h0, d[13:11]},
				{29'h0, rate, xfm, role});
			chk("clip", {31'h0, d[3] & d[20]}, {31'h0, clip});
		end
		// overflow flags: set by an event, cleared by the read that shows them
		for (int k = 0; k < 3; k++)
		begin
			ovf <= 3'h1 << k;
			@(posedge clk_i);
			ovf <= 3'h0;
			rd(A_AUD, ea | (32'h40 << k));
			rd(A_AUD, ea);
		end
		$display("test audio_control done");
		// coefficient storage, byte lane and ignored address bits
		for (int i = 0; i < 3; i++)
		begin
			d = rnd();
			wr(A_COEF, 4'h3, d);
			rd(A_COEF | 8'h3, {16'h0, d[15:0]});
			chk("coef", {16'h0, d[15:0]}, {16'h0, coef});
		end
		wr(A_COEF, 4'h2, 32'h0);
		rd(A_COEF, {16'h0, 8'h00, d[7:0]});
		// unmapped place: acked, reads zero, leaves others alone
		wr(8'h20, 4'h3, rnd());
		rd(8'h20, 32'h0);
		rd(A_PWR, 32'h0000FF3C);
		$display("test coef_unmapped done");
		finish_test();
	end
endmodule

`default_nettype wire
